/* File: eq_defines.svh */
// Constants for the stereo band equalizer
`ifndef EQ_DEFINES_SVH
`define EQ_DEFINES_SVH
`define EQ_SAMPLE_W 24
`define EQ_STATE_W 28
`define EQ_COEF_FRAC 16
`define EQ_K0_FRAC 5
`define EQ_TOTAL_BANDS 20
`define EQ_CH_BANDS 5'h0A
`define EQ_LAST_TEN 4'h9
`define EQ_LAST_FIVE 4'h4
`define EQ_T1_BIT 15
`define EQ_M1_MSB 14
`define EQ_M1_LSB 4
`define EQ_E1_MSB 3
`define EQ_E1_LSB 0
`define EQ_T2_BIT 15
`define EQ_M2_MSB 14
`define EQ_M2_LSB 11
`define EQ_E2_MSB 10
`define EQ_E2_LSB 8
`define EQ_K0_MSB 7
`define EQ_K0_LSB 1
`define EQ_SCALE_BIT 0
`define EQ_FIRST_RST 16'h0000
`define EQ_SECOND_RST 16'h0040
`define EQ_COEF_ONE 18'sh10000
`endif

/* File: eq_types_pkg.sv */
// Types shared by the stereo band equalizer
`default_nettype none
package eq_types_pkg;
  `include "eq_defines.svh"
  typedef struct packed {
    logic signed [`EQ_SAMPLE_W-1:0] left;
    logic signed [`EQ_SAMPLE_W-1:0] right;
  } stereo_t;
  typedef struct packed {
    logic [4:0] band;
    logic second;
    logic [15:0] data;
  } coeff_wr_t;
  typedef enum logic [1:0] {EQ_BYPASS, EQ_FIVE, EQ_TEN} eq_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PUSH} eq_state_t;
endpackage : eq_types_pkg
`default_nettype wire

/* File: param_band_eq.sv */
// Stereo parametric band equalizer with coefficient store and output buffer
// Functional notes
// R1: Modes are bypass, five bands or ten bands per channel.
// R2: One mode setting drives both channels at once.
// R3: Twenty separately programmable band filters in total.
// R4: Output 1 uses bands 1-5 always, bands 6-10 in ten-band mode.
// R5: Output 2 uses bands 11-15 always, bands 16-20 in ten-band mode.
// R6: Pin-strapped control forces bypass whatever coefficients hold.
// R7: Each band's coefficients are written on their own, uncoupled.
// R8: Band output is half(1+A)x plus k0/2 times (1-A)x.
// R9: All-pass numerator K1+K2(1+K1)z^-1+z^-2, denominator mirrored.
// R10: Recover k1 and k2 from packed values using the two flags.
// R11: Packed values are mantissa below one times two to minus exponent.
// R12: First word: flag bit 15, mantissa 14:4, exponent 3:0.
// R13: Second word: flag 15, mantissa 14:11, exponent 10:8, k0 7:1, scale 0.
// R14: Host packs band parameters into two 16-bit words fitting fields.
// R15: Scale flag gives 0 dB when clear, -6 dB when set.
// R16: Each band has a fixed internal -6 dB stage; the code has none beyond the R8 halves and the R15 scale flag.
// R17: At most 12 dB amplification per stage.
// R18: Host computes K0, K1, K2 from gain, frequency and quality.
// R19: Host picks the two flags from frequency and k2 sign.
// R20: Host keeps band gain between -30 dB and +12 dB.
// R21: Host keeps quality 0.001..8, frequency 0.0004..0.49 fs.
// R22: Host places -6 dB scaling on highest safe sections.
// R23: Control-mode selection decides bus versus strapped control.
// R24: One stereo pair per period, saturating math, k0 unsigned fraction.
// R25: New coefficients take effect together at a sample boundary.
`timescale 1ns/1ps
`default_nettype none
`include "eq_defines.svh"
module param_band_eq #(
  parameter int STATE_W = `EQ_STATE_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic bus_ctrl_mode,
  input wire eq_types_pkg::eq_mode_t band_mode_sel,
  input wire logic coeff_wr_en,
  input wire eq_types_pkg::coeff_wr_t coeff_wr,
  output logic [15:0] coeff_rd_data,
  output eq_types_pkg::eq_mode_t mode_active,
  input wire logic in_valid,
  output logic in_ready,
  input wire eq_types_pkg::stereo_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output eq_types_pkg::stereo_t out_data
);
  import eq_types_pkg::*;

  localparam logic signed [47:0] ST_MAX = (48'sh1 <<< (STATE_W - 1)) - 48'sh1;
  localparam logic signed [47:0] SA_MAX = (48'sh1 <<< (`EQ_SAMPLE_W - 1)) - 48'sh1;

  function automatic logic signed [47:0] sat48(input logic signed [47:0] v,
                                              input logic signed [47:0] mx);
    if (v > mx) begin
      sat48 = mx;
    end else if (v < -mx - 48'sh1) begin
      sat48 = -mx - 48'sh1;
    end else begin
      sat48 = v;
    end
  endfunction : sat48

  // Reset release through two flops
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_s2_reg;

  // Control-mode pin filter, change accepted when stages two and three agree
  logic [2:0] strap_reg;
  logic bus_mode_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg <= 3'h0;
      bus_mode_reg <= 1'b0;
    end else begin
      strap_reg <= {strap_reg[1:0], bus_ctrl_mode};
      if (strap_reg[1] == strap_reg[2]) begin
        bus_mode_reg <= strap_reg[2]; // R23
      end
    end
  end

  // Sequencer state and sample path registers
  eq_state_t state_reg;
  eq_mode_t mode_reg;
  logic ch_reg;
  logic [3:0] band_reg;
  logic signed [`EQ_SAMPLE_W-1:0] acc_reg, right_hold_reg, left_res_reg;
  logic [15:0] sh_first_reg [`EQ_TOTAL_BANDS];
  logic [15:0] sh_second_reg [`EQ_TOTAL_BANDS];
  logic [15:0] act_first_reg [`EQ_TOTAL_BANDS];
  logic [15:0] act_second_reg [`EQ_TOTAL_BANDS];
  logic signed [STATE_W-1:0] w1_reg [`EQ_TOTAL_BANDS];
  logic signed [STATE_W-1:0] w2_reg [`EQ_TOTAL_BANDS];
  logic sec_valid_reg;
  stereo_t sec_reg;

  // Mode select, strapped control forces bypass for both channels
  wire take = in_valid & in_ready;
  wire mode_ok = (band_mode_sel == EQ_FIVE) | (band_mode_sel == EQ_TEN);
  wire eq_mode_t eff_mode = (bus_mode_reg & mode_ok) ? band_mode_sel : EQ_BYPASS; // R6 R2 R1
  wire [3:0] last_band = (mode_reg == EQ_TEN) ? `EQ_LAST_TEN : `EQ_LAST_FIVE; // R4 R5
  wire band_done = band_reg == last_band;
  wire [4:0] idx = ch_reg ? 5'(band_reg) + `EQ_CH_BANDS : 5'(band_reg); // R4 R5
  wire buf_full = out_valid & sec_valid_reg;
  wire push = (state_reg == ST_PUSH) & ~buf_full;
  wire pop = out_valid & out_ready;

  // Coefficient decode for the band in flight
  wire [15:0] cf = act_first_reg[idx]; // R14
  wire [15:0] cs = act_second_reg[idx]; // R14
  wire signed [17:0] k1p = $signed({2'h0, cf[`EQ_M1_MSB:`EQ_M1_LSB], 5'h00}
                                   >> cf[`EQ_E1_MSB:`EQ_E1_LSB]); // R12 R11
  wire signed [17:0] k2p = $signed({2'h0, cs[`EQ_M2_MSB:`EQ_M2_LSB], 12'h000}
                                   >> cs[`EQ_E2_MSB:`EQ_E2_LSB]); // R13 R11
  wire signed [17:0] k1 = cf[`EQ_T1_BIT] ? `EQ_COEF_ONE - k1p : k1p - `EQ_COEF_ONE; // R10
  wire signed [17:0] k2 = cs[`EQ_T2_BIT] ? k2p - `EQ_COEF_ONE : `EQ_COEF_ONE - k2p; // R10
  wire signed [17:0] opk1 = `EQ_COEF_ONE + k1;
  wire signed [35:0] a1_full = k2 * opk1;
  wire signed [17:0] a1 = a1_full[33:16]; // R9
  wire signed [47:0] k0 = 48'($signed({1'b0, cs[`EQ_K0_MSB:`EQ_K0_LSB]})); // R24 R17

  // All-pass lattice in direct form, saturating state
  wire signed [STATE_W-1:0] w1c = w1_reg[idx];
  wire signed [STATE_W-1:0] w2c = w2_reg[idx];
  wire signed [47:0] x48 = 48'(acc_reg);
  wire signed [47:0] a1w1 = (48'(a1) * 48'(w1c)) >>> `EQ_COEF_FRAC;
  wire signed [47:0] fb = x48 - a1w1 - ((48'(k1) * 48'(w2c)) >>> `EQ_COEF_FRAC); // R9
  wire signed [47:0] w_sat = sat48(fb, ST_MAX); // R24
  wire signed [47:0] ap = ((48'(k1) * w_sat) >>> `EQ_COEF_FRAC) + a1w1 + 48'(w2c); // R9
  // Band output per R8; no fixed -6 dB stage, a band is unity with k0 of one and scale clear
  wire signed [47:0] half_sum = (x48 + ap) >>> 1; // R8 R16
  wire signed [47:0] k_term = ((x48 - ap) * k0) >>> (`EQ_K0_FRAC + 1); // R8
  wire signed [47:0] h = half_sum + k_term;
  wire signed [47:0] h_sc = cs[`EQ_SCALE_BIT] ? h >>> 1 : h; // R15
  wire signed [47:0] h_sat48 = sat48(h_sc, SA_MAX); // R24
  wire signed [`EQ_SAMPLE_W-1:0] h_sat = h_sat48[`EQ_SAMPLE_W-1:0];

  // Per-band storage: shadow write, commit at sample take, filter state
  genvar g;
  generate
    for (g = 0; g < `EQ_TOTAL_BANDS; g++) begin : g_band
      wire hit_wr = coeff_wr_en & (coeff_wr.band == 5'(g));
      wire hit_run = (state_reg == ST_RUN) & (idx == 5'(g));
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sh_first_reg[g] <= `EQ_FIRST_RST;
          sh_second_reg[g] <= `EQ_SECOND_RST;
          act_first_reg[g] <= `EQ_FIRST_RST;
          act_second_reg[g] <= `EQ_SECOND_RST;
          w1_reg[g] <= '0;
          w2_reg[g] <= '0;
        end else begin
          if (hit_wr & ~coeff_wr.second) begin
            sh_first_reg[g] <= coeff_wr.data; // R7 R3
          end
          if (hit_wr & coeff_wr.second) begin
            sh_second_reg[g] <= coeff_wr.data; // R7 R3
          end
          if (take) begin
            act_first_reg[g] <= sh_first_reg[g]; // R25
            act_second_reg[g] <= sh_second_reg[g]; // R25
          end
          if (hit_run) begin
            w1_reg[g] <= w_sat[STATE_W-1:0];
            w2_reg[g] <= w1_reg[g];
          end
        end
      end
    end
  endgenerate

  // Sample sequencer: left bands, right bands, then hand to buffer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      mode_reg <= EQ_BYPASS;
      in_ready <= 1'b1;
      ch_reg <= 1'b0;
      band_reg <= 4'h0;
      acc_reg <= '0;
      right_hold_reg <= '0;
      left_res_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            mode_reg <= eff_mode; // R2
            in_ready <= 1'b0; // R24
            ch_reg <= 1'b0;
            band_reg <= 4'h0;
            left_res_reg <= in_data.left;
            acc_reg <= (eff_mode == EQ_BYPASS) ? in_data.right : in_data.left;
            right_hold_reg <= in_data.right;
            state_reg <= (eff_mode == EQ_BYPASS) ? ST_PUSH : ST_RUN; // R1 R6
          end
        end
        ST_RUN: begin
          acc_reg <= h_sat;
          band_reg <= band_reg + 4'h1;
          if (band_done & ~ch_reg) begin
            left_res_reg <= h_sat; // R4
            acc_reg <= right_hold_reg;
            ch_reg <= 1'b1;
            band_reg <= 4'h0;
          end else if (band_done) begin
            state_reg <= ST_PUSH; // R5
          end
        end
        ST_PUSH: begin
          if (~buf_full) begin
            in_ready <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Two-entry output buffer; head entry drives the ports
  wire head_free = ~out_valid | pop;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
      sec_valid_reg <= 1'b0;
      sec_reg <= '0;
    end else if (head_free & sec_valid_reg) begin
      out_data <= sec_reg;
      out_valid <= 1'b1;
      sec_valid_reg <= push;
      sec_reg <= {left_res_reg, acc_reg};
    end else if (head_free) begin
      out_valid <= push;
      out_data <= {left_res_reg, acc_reg};
    end else if (push) begin
      sec_valid_reg <= 1'b1;
      sec_reg <= {left_res_reg, acc_reg};
    end
  end

  // Status: shadow readback and applied mode
  wire [15:0] rd_sel = coeff_wr.second ? sh_second_reg[coeff_wr.band]
                                       : sh_first_reg[coeff_wr.band];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coeff_rd_data <= `EQ_FIRST_RST;
      mode_active <= EQ_BYPASS;
    end else begin
      coeff_rd_data <= (coeff_wr.band < 5'(`EQ_TOTAL_BANDS)) ? rd_sel : 16'h0000;
      mode_active <= mode_reg;
    end
  end

  // Checks
  a_strap_bypass: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    take && !bus_mode_reg |=> mode_reg == EQ_BYPASS && state_reg == ST_PUSH)
    else $error("strapped mode did not bypass");
  // Commit checks: mode and coefficients move only at a take
  a_mode_commit: assert property (@(posedge core_clk) disable iff (!rst_n) // R25
    !$stable(mode_reg) |-> $past(take))
    else $error("mode changed outside a sample boundary");
  a_coef_commit: assert property (@(posedge core_clk) disable iff (!rst_n) // R25
    !$stable(act_second_reg[0]) |-> $past(take) && act_second_reg[0] == $past(sh_second_reg[0]))
    else $error("band coefficients changed mid sample");
  // Cascade length: ten (ten-band) or five (five-band) left bands before the right channel starts
  a_ten_span: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    take && eff_mode == EQ_TEN |=> (state_reg == ST_RUN && !ch_reg) [*8] ##1
    (state_reg == ST_RUN && !ch_reg) [*2] ##1 ch_reg && band_reg == 4'h0)
    else $error("ten-band channel one did not run ten bands");
  a_five_span: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
    take && eff_mode == EQ_FIVE |=> ##5 ch_reg && band_reg == 4'h0 ##5 state_reg == ST_PUSH)
    else $error("five-band cascade length wrong");
  // Buffer, handshake and control-mode filter checks
  a_no_overflow: assert property (@(posedge core_clk) disable iff (!rst_n) // R24
    buf_full && !out_ready |-> !push ##1 sec_valid_reg && $stable(sec_reg))
    else $error("output buffer overrun");
  a_out_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // R24
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output dropped while stalled");
  a_one_pair: assert property (@(posedge core_clk) disable iff (!rst_n) // R24
    take |=> !in_ready throughout (state_reg != ST_IDLE) [*1])
    else $error("second sample taken mid processing");
  a_strap_filter: assert property (@(posedge core_clk) disable iff (!rst_n) // R23
    !$stable(bus_mode_reg) |-> $past(strap_reg[1]) == $past(strap_reg[2]))
    else $error("control mode changed without agreement");
endmodule : param_band_eq
`default_nettype wire

/* File: eq_sample_source.sv */
// Upstream sample source that offers stereo words to the equalizer input
`timescale 1ns/1ps
`default_nettype none
module eq_sample_source (
  input wire logic core_clk,
  input wire logic go,
  input wire eq_types_pkg::stereo_t word,
  output logic in_valid,
  input wire logic in_ready,
  output eq_types_pkg::stereo_t in_data,
  output logic took
);
  import eq_types_pkg::*;
  initial begin
    in_valid = 1'b0;
    in_data = '0;
    took = 1'b0;
  end
  // Hold the offer until taken, then scramble the released data lines
  always @(posedge core_clk) begin
    took <= 1'b0;
    if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      in_data <= ~in_data;
      took <= 1'b1;
    end else if (go && !in_valid) begin
      in_valid <= 1'b1;
      in_data <= word;
    end
  end
endmodule : eq_sample_source
`default_nettype wire

/* File: param_band_eq_bench.sv */
// Self-checking bench for the stereo band equalizer
`timescale 1ns/1ps
`default_nettype none
module param_band_eq_bench;
  import eq_types_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic bus_ctrl_mode = 1'b1;
  eq_mode_t band_mode_sel = EQ_BYPASS;
  logic coeff_wr_en = 1'b0;
  coeff_wr_t coeff_wr = '0;
  logic [15:0] coeff_rd_data;
  eq_mode_t mode_active;
  logic in_valid, in_ready, out_valid, took;
  logic go = 1'b0;
  logic out_ready = 1'b1;
  stereo_t in_data, out_data;
  stereo_t word = '0;
  int fails = 0;
  int tests_run = 0;
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  param_band_eq dut_u (.core_clk(core_clk), .rst_b(rst_b), .bus_ctrl_mode(bus_ctrl_mode),
    .band_mode_sel(band_mode_sel), .coeff_wr_en(coeff_wr_en), .coeff_wr(coeff_wr),
    .coeff_rd_data(coeff_rd_data), .mode_active(mode_active), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));
  eq_sample_source src_u (.core_clk(core_clk), .go(go), .word(word), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .took(took));
  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Small rounding slack around a filtered value
  function automatic logic [23:0] near(input logic [23:0] s, input logic [23:0] e);
    logic [23:0] d;
    d = s - e;
    near = (d < 24'h000011 || d > 24'hFFFFEF) ? e : s;
  endfunction : near
  task automatic wr(input int b, input logic s, input logic [15:0] d);
    @(posedge core_clk);
    coeff_wr_en <= 1'b1;
    coeff_wr <= {b[4:0], s, d};
    @(posedge core_clk);
    coeff_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input int b, input logic s, input logic [15:0] e);
    @(posedge core_clk);
    coeff_wr <= {b[4:0], s, 16'h0000};
    repeat (2) @(posedge core_clk);
    #1;
    check("readback", 48'(coeff_rd_data), 48'(e));
  endtask : rd
  // One stereo word through the cascade, timed from its take edge
  task automatic sample(input int lat, input eq_mode_t m, input logic [23:0] el,
    input logic [23:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    word <= {24'h100000, 24'h100000};
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    while (took !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    n = 1; // Take edge counts as the first
    while (out_valid !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("latency", 48'(n), 48'(lat));
    check("mode", 48'(mode_active), 48'(m));
    check("left", 48'(near(out_data.left, el)), 48'(el));
    check("right", 48'(near(out_data.right, er)), 48'(er));
  endtask : sample
  task automatic test_reset();
    repeat (2) @(posedge core_clk);
    #1;
    check("rst_ready", 48'(in_ready), 48'h1);
    check("rst_valid", 48'(out_valid), 48'h0);
    check("rst_mode", 48'(mode_active), 48'(EQ_BYPASS));
    @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(0, 1'b0, 16'h0000);
    rd(19, 1'b1, 16'h0040);
  endtask : test_reset
  task automatic test_coeff();
    for (int b = 0; b < 20; b++) begin
      wr(b, 1'b0, 16'hA500 ^ 16'(b));
      wr(b, 1'b1, 16'h5A00 ^ 16'(b * 3));
    end
    wr(20, 1'b0, 16'hFFFF);
    for (int b = 0; b < 21; b++) begin
      rd(b, 1'b0, b < 20 ? 16'hA500 ^ 16'(b) : 16'h0000);
      rd(b, 1'b1, b < 20 ? 16'h5A00 ^ 16'(b * 3) : 16'h0000);
    end
    // Unity gain, k1 -0.5, k2 +0.5, both flags clear
    for (int b = 0; b < 20; b++) begin
      wr(b, 1'b0, 16'h4000);
      wr(b, 1'b1, 16'h4040);
    end
  endtask : test_coeff
  task automatic test_modes();
    eq_mode_t ms[4] = '{EQ_BYPASS, EQ_FIVE, EQ_TEN, eq_mode_t'(2'h3)};
    int lats[4] = '{2, 12, 22, 2};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      band_mode_sel <= ms[i];
      sample(lats[i], i == 3 ? EQ_BYPASS : ms[i], 24'h100000, 24'h100000);
    end
  endtask : test_modes
  task automatic test_scale();
    wr(4, 1'b1, 16'h4041);
    wr(9, 1'b1, 16'h4041);
    wr(19, 1'b1, 16'h4041);
    band_mode_sel <= EQ_FIVE;
    sample(12, EQ_FIVE, 24'h080000, 24'h100000);
    @(posedge core_clk);
    band_mode_sel <= EQ_TEN;
    sample(22, EQ_TEN, 24'h040000, 24'h080000);
    @(posedge core_clk);
    bus_ctrl_mode <= 1'b0;
    repeat (6) @(posedge core_clk);
    sample(2, EQ_BYPASS, 24'h100000, 24'h100000);
    @(posedge core_clk);
    bus_ctrl_mode <= 1'b1;
  endtask : test_scale
  // Stall the sink: two words buffered, one parked, one refused
  task automatic test_buffer();
    int k;
    k = 0;
    @(posedge core_clk);
    band_mode_sel <= EQ_BYPASS;
    out_ready <= 1'b0;
    for (int i = 1; i <= 4; i++) begin
      @(posedge core_clk);
      word <= {24'(i), 24'(i)};
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
    #1;
    check("full_ready", 48'(in_ready), 48'h0);
    @(posedge core_clk);
    out_ready <= 1'b1;
    repeat (40) begin
      #1;
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        k++;
        check("drain", out_data, {24'(k), 24'(k)});
      end
      @(posedge core_clk);
    end
    check("drain_count", 48'(k), 48'h4);
  endtask : test_buffer
  initial begin
    test_reset();
    test_coeff();
    test_modes();
    test_scale();
    test_buffer();
    report_and_stop();
  end
  // Watchdog: the sequence needs well under 3000 cycles
  initial begin
    #40000;
    fails++;
    report_and_stop();
  end
endmodule : param_band_eq_bench
`default_nettype wire
